/* File: src/bbv_pkg.sv */
// Function
// - short-long-short: rising edge sends short telegram at once, starts first_phase_timer.
// - short-long-short: release before first_phase_timer ends sends nothing more.
// - short-long-short: held past first_phase_timer sends long telegram, starts slat_adjust_timer.
// - short-long-short: release while slat_adjust_timer runs sends one more short telegram.
// - short-long-short: held beyond slat_adjust_timer sends nothing more, even on release.
// - long-short: rising edge sends long telegram at once, starts slat_adjust_timer.
// - long-short: release while slat_adjust_timer runs sends a short telegram.
// - long-short: held beyond slat_adjust_timer sends nothing more.
// - direction setting makes blind telegrams up, down or toggling.
// - value kind select: dimming and scene one byte, temperature and brightness two.
// - dimming values are unsigned integers from 0 to 255.
// - brightness floats span 0 to 1500 lux, temperature floats 0 to 40 C.
// - edge selection sends values on rising, falling or both edges.
// - value adjustment only with rising-only or falling-only edge selection.
// - adjustment starts after more than 5 s of actuation, runs while held.
// - adjustment steps and sends repeatedly; first ever adjustment goes upward.
// - temperature step fixed at 1 K, brightness step fixed at 50 lux.
// - release keeps last value; next long actuation reverses direction from it.
// - interval between adjustment telegrams is configurable.
// - no wrap past limits; at a limit, adjustment telegrams stop.
// - overshooting step sends the limit; first step after reversal restores grid.
// - adjusted value is volatile; device reset restores configured value.
// - during start-up delay after reset or bus return, edges are discarded.
// - with rate limit enabled, no telegram in the first 17 s after bus return.
package bbv_pkg;
  // time base
  localparam int CLK_NS = 10;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_NS;
  localparam int ADJ_START_MS = 5000;
  localparam int ADJ_START_TICKS = (ADJ_START_MS + TICK_MS - 1) / TICK_MS;
  localparam int RATE_HOLD_MS = 17000;
  localparam int RATE_HOLD_TICKS = (RATE_HOLD_MS + TICK_MS - 1) / TICK_MS;
  localparam int DEBOUNCE_TICKS = 3;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_T1 = 8'h04;
  localparam logic [7:0] REG_T2 = 8'h08;
  localparam logic [7:0] REG_REPEAT = 8'h0c;
  localparam logic [7:0] REG_STARTUP = 8'h10;
  localparam logic [7:0] REG_STEP = 8'h14;
  localparam logic [7:0] REG_VALUE = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  // control fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_CONCEPT_BIT = 1;
  localparam int CTRL_DIR_LSB = 2;
  localparam int CTRL_KIND_LSB = 4;
  localparam int CTRL_EDGE_LSB = 6;
  localparam int CTRL_ADJ_BIT = 8;
  localparam int CTRL_RATE_BIT = 9;
  localparam logic [1:0] DIR_UP = 2'h0;
  localparam logic [1:0] DIR_DOWN = 2'h1;
  localparam logic [1:0] DIR_TOGGLE = 2'h2;
  localparam logic [1:0] KIND_DIM = 2'h0;
  localparam logic [1:0] KIND_TEMP = 2'h1;
  localparam logic [1:0] KIND_BRIGHT = 2'h2;
  localparam logic [1:0] KIND_SCENE = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // status fields, working value in the low half
  localparam int STAT_LEVEL_BIT = 16;
  localparam int STAT_START_BIT = 17;
  localparam int STAT_RATE_BIT = 18;
  localparam int STAT_DIR_BIT = 19;
  // reset values, times in ticks
  localparam logic [15:0] CTRL_RST = 16'h0040;
  localparam logic [15:0] T1_RST = 16'h0028;
  localparam logic [15:0] T2_RST = 16'h0032;
  localparam logic [15:0] REP_RST = 16'h0032;
  localparam logic [15:0] STARTUP_RST = 16'h000a;
  localparam logic [7:0] STEP_RST = 8'h05;
  localparam logic [15:0] VALUE_RST = 16'h0011;
  // value limits and fixed steps
  localparam logic [15:0] DIM_MAX = 16'h00ff;
  localparam logic [15:0] TEMP_MAX = 16'h0028;
  localparam logic [15:0] BRIGHT_MAX = 16'h05dc;
  localparam logic [15:0] TEMP_STEP = 16'h0001;
  localparam logic [15:0] BRIGHT_STEP = 16'h0032;
  localparam int FLOAT_SCALE = 100;
  typedef enum logic [1:0] {TG_SHORT, TG_LONG, TG_VALUE} bbv_tg_t;
endpackage

/* File: src/bbv_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
module bbv_debounce #(
  parameter int DebounceTicks = bbv_pkg::DEBOUNCE_TICKS
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic pinIn,
  input wire logic tick,
  output logic level,
  output logic riseEv,
  output logic fallEv
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
    logic [7:0] cnt;
    logic rise;
    logic fall;
  } bbv_deb_t;
  bbv_deb_t q, d;

  // a new level must hold for whole ticks before it counts
  always_comb begin
    d = q;
    d.s1 = pinIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rise = 1'b0;
    d.fall = 1'b0;
    if (q.s2 != q.s3 || q.s3 == q.stable) begin
      d.cnt = 8'h00;
    end else if (tick) begin
      if (q.cnt >= 8'(DebounceTicks - 1)) begin
        d.cnt = 8'h00;
        d.stable = q.s3;
        d.rise = q.s3;
        d.fall = !q.s3;
      end else begin
        d.cnt = q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.stable;
  assign riseEv = q.rise;
  assign fallEv = q.fall;
endmodule
`default_nettype wire

/* File: src/bbv_value_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
module bbv_value_encoder (
  input wire logic [1:0] kind,
  input wire logic [15:0] value,
  output logic [15:0] payload,
  output logic twoByte
);
  // two-byte float: sign, 4-bit exponent, 11-bit mantissa of value*100
  function automatic logic [15:0] toFloat(input logic [15:0] v);
    logic [17:0] m;
    logic [3:0] e;
    m = 18'(32'(v) * bbv_pkg::FLOAT_SCALE);
    e = 4'h0;
    for (int i = 0; i < 7; i++) begin
      if (m > 18'h007ff) begin
        m = m >> 1;
        e = e + 4'h1;
      end
    end
    return {1'b0, e, m[10:0]};
  endfunction

  // one byte for dimming and scene, float for the rest
  always_comb begin
    twoByte = (kind == bbv_pkg::KIND_TEMP) || (kind == bbv_pkg::KIND_BRIGHT);
    payload = twoByte ? toFloat(value) : {8'h00, value[7:0]};
  end
endmodule
`default_nettype wire

/* File: src/bbv_button_blind_value_sender.sv */
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module bbv_button_blind_value_sender #(
  parameter int TickCycles = bbv_pkg::TICK_CYCLES,
  parameter int AdjStartTicks = bbv_pkg::ADJ_START_TICKS,
  parameter int RateHoldTicks = bbv_pkg::RATE_HOLD_TICKS,
  parameter int DebounceTicks = bbv_pkg::DEBOUNCE_TICKS
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic contactIn,
  input wire logic busReturn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic txValid,
  output bbv_pkg::bbv_tg_t txKind,
  output logic txUpDown,
  output logic [15:0] txData,
  output logic txTwoByte
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_T2, ST_WAIT, ST_HOLD, ST_ADJ
  } bbv_fsm_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] t1;
    logic [15:0] t2;
    logic [15:0] rep;
    logic [15:0] startup;
    logic [7:0] step;
    logic [15:0] cfgVal;
    logic [31:0] rdData;
    logic [31:0] tickCnt;
    logic tick;
    logic [15:0] startCnt;
    logic startDone;
    logic [15:0] rateCnt;
    logic rateDone;
    bbv_fsm_t st;
    logic [15:0] tmr;
    logic [15:0] holdCnt;
    logic [15:0] val;
    logic dirDown;
    logic clipped;
    logic [15:0] shortStep;
    logic toggle;
    logic txValid;
    bbv_pkg::bbv_tg_t txKind;
    logic txUpDown;
    logic [15:0] txData;
    logic txTwo;
  } bbv_state_t;

  bbv_state_t q, d;

  logic level;
  logic riseEv;
  logic fallEv;
  logic [15:0] sendVal;
  logic [15:0] encData;
  logic encTwo;
  logic valueMode;
  logic concept;
  logic [1:0] dirSel;
  logic [1:0] kind;
  logic [1:0] edgeSel;
  logic adjOk;
  logic rateOk;
  logic actLevel;
  logic startEv;

  // upper bound of the working value per kind
  function automatic logic [15:0] limitOf(input logic [1:0] k);
    case (k)
      bbv_pkg::KIND_TEMP: return bbv_pkg::TEMP_MAX;
      bbv_pkg::KIND_BRIGHT: return bbv_pkg::BRIGHT_MAX;
      default: return bbv_pkg::DIM_MAX;
    endcase
  endfunction

  // adjustment step; only dimming takes the programmed width
  function automatic logic [15:0] stepOf(input logic [1:0] k,
                                         input logic [7:0] s);
    case (k)
      bbv_pkg::KIND_TEMP: return bbv_pkg::TEMP_STEP;
      bbv_pkg::KIND_BRIGHT: return bbv_pkg::BRIGHT_STEP;
      default: return {8'h00, s};
    endcase
  endfunction

  // contact conditioning shares the slow tick with all timers
  bbv_debounce #(
    .DebounceTicks(DebounceTicks)
  ) u_deb (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pinIn(contactIn),
    .tick(q.tick),
    .level(level),
    .riseEv(riseEv),
    .fallEv(fallEv)
  );

  bbv_value_encoder u_enc (
    .kind(kind),
    .value(sendVal),
    .payload(encData),
    .twoByte(encTwo)
  );

  // control fields
  assign valueMode = q.ctrl[bbv_pkg::CTRL_MODE_BIT];
  assign concept = q.ctrl[bbv_pkg::CTRL_CONCEPT_BIT];
  assign dirSel = q.ctrl[bbv_pkg::CTRL_DIR_LSB +: 2];
  assign kind = q.ctrl[bbv_pkg::CTRL_KIND_LSB +: 2];
  assign edgeSel = q.ctrl[bbv_pkg::CTRL_EDGE_LSB +: 2];
  assign rateOk = !q.ctrl[bbv_pkg::CTRL_RATE_BIT] || q.rateDone;
  // never with both edges, never for scenes
  assign adjOk = q.ctrl[bbv_pkg::CTRL_ADJ_BIT] && kind != bbv_pkg::KIND_SCENE
    && (edgeSel == bbv_pkg::EDGE_RISE || edgeSel == bbv_pkg::EDGE_FALL);
  // a break contact is actuated while its input is low
  assign actLevel = (edgeSel == bbv_pkg::EDGE_FALL) ? !level : level;
  assign startEv = (edgeSel == bbv_pkg::EDGE_FALL) ? fallEv : riseEv;

  always_comb begin
    logic snd;
    logic ud;
    logic doStep;
    logic [15:0] stp;
    logic [15:0] lim;
    bbv_pkg::bbv_tg_t sk;
    snd = 1'b0;
    ud = 1'b0;
    doStep = 1'b0;
    sk = bbv_pkg::TG_SHORT;
    stp = 16'h0000;
    lim = limitOf(kind);
    d = q;
    sendVal = q.val;
    d.tick = 1'b0;
    d.txValid = 1'b0;
    d.rdData = 32'h0000_0000;

    // common slow time base
    if (q.tickCnt >= 32'(TickCycles - 1)) begin
      d.tickCnt = 32'h0000_0000;
      d.tick = 1'b1;
    end else begin
      d.tickCnt = q.tickCnt + 32'h0000_0001;
    end

    // start-up delay and rate-limit hold both count ticks
    if (q.tick && !q.startDone) begin
      if (q.startCnt + 16'h0001 >= q.startup) begin
        d.startDone = 1'b1;
      end else begin
        d.startCnt = q.startCnt + 16'h0001;
      end
    end
    if (q.tick && !q.rateDone) begin
      if (q.rateCnt + 16'h0001 >= 16'(RateHoldTicks)) begin
        d.rateDone = 1'b1;
      end else begin
        d.rateCnt = q.rateCnt + 16'h0001;
      end
    end

    // toggle polarity flips once per actuation, kept for its later telegrams
    if (dirSel == bbv_pkg::DIR_TOGGLE) begin
      ud = (q.st == ST_IDLE) ? !q.toggle : q.toggle;
    end else begin
      ud = (dirSel == bbv_pkg::DIR_DOWN);
    end

    case (q.st)
      ST_IDLE: begin
        if (!valueMode) begin
          if (riseEv) begin
            snd = 1'b1;
            d.tmr = 16'h0000;
            d.toggle = ud;
            if (concept) begin
              sk = bbv_pkg::TG_LONG;
              d.st = ST_T2;
            end else begin
              sk = bbv_pkg::TG_SHORT;
              d.st = ST_T1;
            end
          end
        end else begin
          if ((riseEv && edgeSel[0]) || (fallEv && edgeSel[1])) begin
            snd = 1'b1;
            sk = bbv_pkg::TG_VALUE;
          end
          if (adjOk && startEv) begin
            d.st = ST_HOLD;
            d.holdCnt = 16'h0000;
          end
        end
      end
      ST_T1: begin
        if (fallEv) begin
          d.st = ST_IDLE;
        end else if (q.tick) begin
          if (q.tmr + 16'h0001 >= q.t1) begin
            snd = 1'b1;
            sk = bbv_pkg::TG_LONG;
            d.st = ST_T2;
            d.tmr = 16'h0000;
          end else begin
            d.tmr = q.tmr + 16'h0001;
          end
        end
      end
      ST_T2: begin
        if (fallEv) begin
          snd = 1'b1;
          sk = bbv_pkg::TG_SHORT;
          d.st = ST_IDLE;
        end else if (q.tick) begin
          if (q.tmr + 16'h0001 >= q.t2) begin
            d.st = ST_WAIT;
          end else begin
            d.tmr = q.tmr + 16'h0001;
          end
        end
      end
      ST_WAIT: begin
        // drive runs to its end position, release stays silent
        if (fallEv) begin
          d.st = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (!actLevel) begin
          d.st = ST_IDLE;
        end else if (q.tick) begin
          if (q.holdCnt >= 16'(AdjStartTicks)) begin
            d.st = ST_ADJ;
            d.tmr = 16'h0000;
            doStep = 1'b1;
          end else begin
            d.holdCnt = q.holdCnt + 16'h0001;
          end
        end
      end
      ST_ADJ: begin
        if (!actLevel) begin
          d.st = ST_IDLE;
          d.dirDown = !q.dirDown;
        end else if (q.tick) begin
          if (q.tmr + 16'h0001 >= q.rep) begin
            d.tmr = 16'h0000;
            doStep = 1'b1;
          end else begin
            d.tmr = q.tmr + 16'h0001;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // one adjustment step; a clipped step is remembered so that the
    // first step after reversal lands back on the original grid
    if (doStep) begin
      stp = q.clipped ? q.shortStep : stepOf(kind, q.step);
      if (q.dirDown) begin
        if (q.val != 16'h0000) begin
          snd = 1'b1;
          sk = bbv_pkg::TG_VALUE;
          if (q.val < stp) begin
            d.val = 16'h0000;
            d.clipped = 1'b1;
            d.shortStep = q.val;
          end else begin
            d.val = q.val - stp;
            d.clipped = 1'b0;
          end
        end
      end else if (q.val < lim) begin
        snd = 1'b1;
        sk = bbv_pkg::TG_VALUE;
        if (lim - q.val < stp) begin
          d.val = lim;
          d.clipped = 1'b1;
          d.shortStep = lim - q.val;
        end else begin
          d.val = q.val + stp;
          d.clipped = 1'b0;
        end
      end
      sendVal = d.val;
    end

    // edges within the start-up delay are dropped, not deferred
    if (!q.startDone) begin
      d.st = ST_IDLE;
      snd = 1'b0;
    end

    // telegram register; the rate hold only blocks the send
    d.txValid = snd && rateOk;
    if (snd) begin
      d.txKind = sk;
      d.txUpDown = ud;
      d.txData = (sk == bbv_pkg::TG_VALUE) ? encData : {15'h0000, ud};
      d.txTwo = (sk == bbv_pkg::TG_VALUE) && encTwo;
    end

    // register writes; a new programmed value also resets adjustment
    if (regWr) begin
      case (regAddr)
        bbv_pkg::REG_CTRL: d.ctrl = regWrData[15:0];
        bbv_pkg::REG_T1: d.t1 = regWrData[15:0];
        bbv_pkg::REG_T2: d.t2 = regWrData[15:0];
        bbv_pkg::REG_REPEAT: d.rep = regWrData[15:0];
        bbv_pkg::REG_STARTUP: d.startup = regWrData[15:0];
        bbv_pkg::REG_STEP: d.step = regWrData[7:0];
        bbv_pkg::REG_VALUE: begin
          d.cfgVal = regWrData[15:0];
          d.val = regWrData[15:0];
          d.dirDown = 1'b0;
          d.clipped = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // bus voltage return acts as a device reset for the channel
    if (busReturn) begin
      d.startDone = 1'b0;
      d.startCnt = 16'h0000;
      d.rateDone = 1'b0;
      d.rateCnt = 16'h0000;
      d.val = q.cfgVal;
      d.dirDown = 1'b0;
      d.clipped = 1'b0;
      d.st = ST_IDLE;
    end

    // read data stands only in the cycle after the strobe
    if (regRd) begin
      case (regAddr)
        bbv_pkg::REG_CTRL: d.rdData = {16'h0000, q.ctrl};
        bbv_pkg::REG_T1: d.rdData = {16'h0000, q.t1};
        bbv_pkg::REG_T2: d.rdData = {16'h0000, q.t2};
        bbv_pkg::REG_REPEAT: d.rdData = {16'h0000, q.rep};
        bbv_pkg::REG_STARTUP: d.rdData = {16'h0000, q.startup};
        bbv_pkg::REG_STEP: d.rdData = {24'h000000, q.step};
        bbv_pkg::REG_VALUE: d.rdData = {16'h0000, q.cfgVal};
        bbv_pkg::REG_STATUS: begin
          d.rdData = {16'h0000, q.val};
          d.rdData[bbv_pkg::STAT_LEVEL_BIT] = level;
          d.rdData[bbv_pkg::STAT_START_BIT] = q.startDone;
          d.rdData[bbv_pkg::STAT_RATE_BIT] = q.rateDone;
          d.rdData[bbv_pkg::STAT_DIR_BIT] = q.dirDown;
        end
        default: d.rdData = 32'h0000_0000;
      endcase
    end
  end

  // device reset loads the reset values from the package
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{
        ctrl: bbv_pkg::CTRL_RST,
        t1: bbv_pkg::T1_RST,
        t2: bbv_pkg::T2_RST,
        rep: bbv_pkg::REP_RST,
        startup: bbv_pkg::STARTUP_RST,
        step: bbv_pkg::STEP_RST,
        cfgVal: bbv_pkg::VALUE_RST,
        val: bbv_pkg::VALUE_RST,
        st: ST_IDLE,
        txKind: bbv_pkg::TG_SHORT,
        default: '0
      };
    end else begin
      q <= d;
    end
  end

  assign regRdData = q.rdData;
  assign txValid = q.txValid;
  assign txKind = q.txKind;
  assign txUpDown = q.txUpDown;
  assign txData = q.txData;
  assign txTwoByte = q.txTwo;

  // checks on the telegram sequencing
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence sBlindRise(c);
    q.startDone && rateOk && !busReturn && !valueMode && concept == c
      && q.st == ST_IDLE && riseEv;
  endsequence
  sequence sShort;
    q.txValid && q.txKind == bbv_pkg::TG_SHORT;
  endsequence
  sequence sLong;
    q.txValid && q.txKind == bbv_pkg::TG_LONG;
  endsequence

  sls_short_a: assert property (sBlindRise(1'b0) |=> sShort ##0 q.st == ST_T1)
    else $error("rising edge did not send short telegram");
  ls_long_a: assert property (sBlindRise(1'b1) |=> sLong ##0 q.st == ST_T2)
    else $error("rising edge did not send long telegram");
  sls_release_a: assert property (q.st == ST_T1 && fallEv |=>
    !q.txValid && q.st == ST_IDLE)
    else $error("early release sent a telegram");
  t1_long_a: assert property (q.st == ST_T1 && !fallEv && q.tick && rateOk
    && !busReturn && q.tmr + 16'h0001 >= q.t1 |=> sLong ##0 q.st == ST_T2)
    else $error("first phase expiry did not send long telegram");
  slat_short_a: assert property (q.st == ST_T2 && fallEv && rateOk
    && !busReturn |=> sShort ##0 q.st == ST_IDLE)
    else $error("release in slat time did not send short telegram");
  wait_quiet_a: assert property (q.st == ST_WAIT |=> !q.txValid)
    else $error("telegram sent after slat time");
  rate_block_a: assert property (!rateOk |=> !q.txValid)
    else $error("telegram sent during rate hold");
  startup_a: assert property (!q.startDone |=> !q.txValid && q.st == ST_IDLE)
    else $error("edge evaluated during start-up delay");
  hold_adj_a: assert property (q.st == ST_HOLD && q.tick && actLevel
    && q.startDone && !busReturn && q.holdCnt >= 16'(AdjStartTicks)
    |=> q.st == ST_ADJ)
    else $error("adjustment did not start after hold time");
  limit_stop_a: assert property (q.st == ST_ADJ && !q.dirDown && !regWr
    && !busReturn && q.val >= limitOf(kind) |=> $stable(q.val) && !q.txValid)
    else $error("value stepped past its limit");
  dir_flip_a: assert property (q.st == ST_ADJ && !actLevel && !regWr
    && !busReturn |=> q.dirDown != $past(q.dirDown))
    else $error("adjustment direction not reversed on release");
endmodule
`default_nettype wire

/* File: verification/bbv_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// passive actuator side of the bus: logs the first 256 telegrams handed over
module bbv_bus_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic txValid,
  input wire bbv_pkg::bbv_tg_t txKind,
  input wire logic txUpDown,
  input wire logic [15:0] txData,
  input wire logic txTwoByte
);
  bbv_pkg::bbv_tg_t kinds [0:255];
  logic [15:0] datas [0:255];
  logic upDowns [0:255];
  logic twoBytes [0:255];
  int cnt = 0;
  // the request stands one cycle, so it is taken at that edge; updates are
  // non-blocking so a reader at the same edge always sees the older log
  always @(posedge ref_clk) begin
    if (rst_b === 1'b1 && txValid === 1'b1 && cnt < 256) begin
      kinds[cnt] <= txKind;
      datas[cnt] <= txData;
      upDowns[cnt] <= txUpDown;
      twoBytes[cnt] <= txTwoByte;
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/bbv_button_blind_value_sender_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module bbv_button_blind_value_sender_bench;
  localparam int TickCyc = 10;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic contactIn = 1'b0;
  logic busReturn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic txValid;
  logic txUpDown;
  logic txTwoByte;
  logic [15:0] txData;
  bbv_pkg::bbv_tg_t txKind;
  int fails = 0;
  int samplesChecked = 0;
  int cyc = 0;
  int b;
  // short tick and adjust start keep the run to a few thousand cycles
  bbv_button_blind_value_sender #(.TickCycles(TickCyc), .AdjStartTicks(5),
    .RateHoldTicks(20), .DebounceTicks(1)) i_dut (.ref_clk(ref_clk),
    .rst_b(rst_b), .contactIn(contactIn), .busReturn(busReturn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .txValid(txValid), .txKind(txKind),
    .txUpDown(txUpDown), .txData(txData), .txTwoByte(txTwoByte));
  bbv_bus_model i_bus (.ref_clk(ref_clk), .rst_b(rst_b), .txValid(txValid),
    .txKind(txKind), .txUpDown(txUpDown), .txData(txData),
    .txTwoByte(txTwoByte));
  always #5 ref_clk = ~ref_clk;
  // hang guard, well above the expected few thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tallyAndFinish();
    end
  end
  task automatic tallyAndFinish();
    if (fails == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(logic [31:0] got, logic [31:0] exp, string what);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tk(int n);
    repeat (n * TickCyc) @(posedge ref_clk);
  endtask
  // a gap cycle after each strobe keeps one driver assignment per step
  task automatic wr(logic [7:0] a, logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 cmp(regRdData, e, "read data");
    @(posedge ref_clk);
  endtask
  task automatic press(int on, int after);
    contactIn <= 1'b1;
    tk(on);
    contactIn <= 1'b0;
    tk(after);
  endtask
  task automatic cnt(int n);
    cmp(32'(i_bus.cnt - b), 32'(n), "telegram count");
  endtask
  task automatic tg(int i, bbv_pkg::bbv_tg_t k, logic [15:0] d);
    cmp(32'(i_bus.kinds[i]), 32'(k), "kind");
    cmp({16'h0, i_bus.datas[i]}, {16'h0, d}, "payload");
  endtask
  task automatic regsTask();
    rd(bbv_pkg::REG_CTRL, 32'h0000_0040);
    rd(bbv_pkg::REG_T1, 32'h0000_0028);
    rd(8'h20, 32'h0);
    wr(bbv_pkg::REG_T1, 32'h4);
    wr(bbv_pkg::REG_T2, 32'h6);
    wr(bbv_pkg::REG_REPEAT, 32'h2);
    rd(bbv_pkg::REG_T2, 32'h6);
  endtask
  // short-long-short, direction down: tap, slat release, long hold
  task automatic slsTask();
    wr(bbv_pkg::REG_CTRL, 32'h0004);
    b = i_bus.cnt;
    press(2, 5);
    cnt(1);
    tg(b, bbv_pkg::TG_SHORT, 16'h0001);
    b = i_bus.cnt;
    press(7, 5);
    cnt(3);
    tg(b + 1, bbv_pkg::TG_LONG, 16'h0001);
    tg(b + 2, bbv_pkg::TG_SHORT, 16'h0001);
    b = i_bus.cnt;
    press(14, 5);
    cnt(2);
  endtask
  task automatic lsTask();
    wr(bbv_pkg::REG_CTRL, 32'h0002);
    b = i_bus.cnt;
    press(3, 5);
    tg(b, bbv_pkg::TG_LONG, 16'h0000);
    tg(b + 1, bbv_pkg::TG_SHORT, 16'h0000);
    b = i_bus.cnt;
    press(9, 5);
    cnt(1);
  endtask
  task automatic toggleTask();
    wr(bbv_pkg::REG_CTRL, 32'h0008);
    b = i_bus.cnt;
    press(2, 5);
    press(2, 5);
    cmp({31'h0, i_bus.upDowns[b + 1]}, {31'h0, !i_bus.upDowns[b]}, "toggle");
  endtask
  // dim from 17 in steps of 5 up to the clipped 255, then reverse
  task automatic dimTask();
    wr(bbv_pkg::REG_CTRL, 32'h0141);
    b = i_bus.cnt;
    press(120, 5);
    cnt(49);
    tg(b, bbv_pkg::TG_VALUE, 16'h0011);
    cmp(32'(i_bus.twoBytes[b]), 32'h0, "one byte");
    tg(b + 1, bbv_pkg::TG_VALUE, 16'h0016);
    tg(b + 48, bbv_pkg::TG_VALUE, 16'h00ff);
    b = i_bus.cnt;
    press(9, 5);
    tg(b, bbv_pkg::TG_VALUE, 16'h00ff);
    tg(b + 1, bbv_pkg::TG_VALUE, 16'h00fc);
  endtask
  task automatic edgeTask();
    wr(bbv_pkg::REG_CTRL, 32'h0081);
    b = i_bus.cnt;
    contactIn <= 1'b1;
    tk(3);
    cnt(0);
    contactIn <= 1'b0;
    tk(4);
    cnt(1);
    wr(bbv_pkg::REG_CTRL, 32'h01c1);
    b = i_bus.cnt;
    press(10, 5);
    cnt(2);
  endtask
  // brightness 1480 lux, then one 50 lux step clipped to 1500, then silence
  // temperature 17 K and 18 K as two-byte floats in 0.01 units
  task automatic tempTask();
    wr(bbv_pkg::REG_CTRL, 32'h0161);
    wr(bbv_pkg::REG_VALUE, 32'h05c8);
    b = i_bus.cnt;
    press(8, 5);
    cnt(2);
    tg(b, bbv_pkg::TG_VALUE, 16'h3c84);
    tg(b + 1, bbv_pkg::TG_VALUE, 16'h3c93);
    wr(bbv_pkg::REG_CTRL, 32'h0151);
    wr(bbv_pkg::REG_VALUE, 32'h0011);
    b = i_bus.cnt;
    press(8, 5);
    tg(b, bbv_pkg::TG_VALUE, 16'h06a4);
    cmp(32'(i_bus.twoBytes[b]), 32'h1, "two byte");
    tg(b + 1, bbv_pkg::TG_VALUE, 16'h0708);
  endtask
  // start-up delay alone first, rate hold off, so only the delay can block
  task automatic returnTask();
    wr(bbv_pkg::REG_CTRL, 32'h0141);
    busReturn <= 1'b1;
    @(posedge ref_clk);
    busReturn <= 1'b0;
    rd(bbv_pkg::REG_STATUS, 32'h0000_0011);
    b = i_bus.cnt;
    tk(2);
    press(3, 8);
    cnt(0);
    rd(bbv_pkg::REG_STATUS, 32'h0002_0011);
    wr(bbv_pkg::REG_CTRL, 32'h0341);
    busReturn <= 1'b1;
    @(posedge ref_clk);
    busReturn <= 1'b0;
    tk(11);
    press(2, 5);
    cnt(0);
    tk(5);
    press(2, 5);
    cnt(1);
    tg(b, bbv_pkg::TG_VALUE, 16'h0011);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    regsTask();
    tk(14);
    slsTask();
    lsTask();
    toggleTask();
    dimTask();
    edgeTask();
    tempTask();
    returnTask();
    tallyAndFinish();
  end
endmodule
`default_nettype wire
